// File: rtl/pmg_top.sv
/*
  Multi-edge pulse generator: prescaler, shared cycle counter, repeat
  control, trigger synchroniser, completion flag and eight output lines.
  Assumes a single system clock; setup ports are static while running.
*/
// Operation
// - Eight independent pulse outputs are all timed from one shared cycle counter.
// - A 16-bit up-counter sets the length of one pulse cycle through its programmed range.
// - The counter advances on system clocks, optionally divided by an 8-bit prescaler.
// - Each output has eight transition points, giving up to four pulses per cycle.
// - An output inverts when the counter equals one of its transition values, except at the terminal value, where it reloads.
// - Each output starts every cycle at its own software-chosen initial level.
// - Each output has its own enable and shows a waveform only while enabled.
// - The generator runs continuously or for a programmed 1 to 255 cycles, then stops.
// - A sequence starts on a software start command or on the external trigger input.
`timescale 1ns/1ps
`default_nettype none

module pmg_top (
  // Clock and reset
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RESETN_IN,
  // Setup
  input  wire pmg_pkg::pmg_cfg_t     CFG_IN,
  input  wire pmg_pkg::pmg_chan_tab_t CHAN_IN,
  // Commands
  input  wire logic                  START_IN,
  input  wire logic                  STOP_IN,
  input  wire logic                  TRIG_IN,
  input  wire logic                  DONE_CLR_IN,
  // Output lines and status
  output logic [pmg_pkg::NUM_OUT-1:0] PWM_OUT,
  output pmg_pkg::pmg_cnt_t          CNT_OUT,
  output logic                       BUSY_OUT,
  output logic                       DONE_OUT,
  output logic                       IRQ_OUT
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pmg_pkg::pmg_cnt_t          cnt_q;
  pmg_pkg::pmg_cnt_t          cnt_d;
  logic [pmg_pkg::PRE_W-1:0]  presc_q;
  logic [pmg_pkg::PRE_W-1:0]  presc_d;
  logic [pmg_pkg::REP_W-1:0]  rem_q;
  logic [pmg_pkg::REP_W-1:0]  rem_d;
  logic                       run_q;
  logic                       run_d;
  logic                       done_q;
  logic                       done_d;
  logic                       irq_q;
  logic                       trig_s1_q;
  logic                       trig_s2_q;
  logic                       trig_s3_q;

  logic                       tick_w;
  logic                       at_term_w;
  logic                       wrap_w;
  logic                       last_w;
  logic                       trig_rise_w;
  logic                       start_w;
  logic                       stop_w;
  logic [pmg_pkg::REP_W-1:0]  rep_load_w;

  // ----------------------------------------------------------------------
  // Trigger synchroniser and edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= TRIG_IN;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_rise_w = trig_s2_q && !trig_s3_q;

  // ----------------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------------
  // Starts while running are ignored so a trigger cannot restart mid-cycle
  assign start_w = !run_q && (START_IN || (CFG_IN.trig_en && trig_rise_w));

  assign tick_w    = !CFG_IN.presc_en || (presc_q == CFG_IN.prescale);
  assign at_term_w = (cnt_q == CFG_IN.terminal);
  assign wrap_w    = run_q && tick_w && at_term_w;
  assign last_w    = wrap_w && !CFG_IN.continuous && (rem_q <= pmg_pkg::REP_ONE);
  assign stop_w    = run_q && (last_w || STOP_IN);

  // A count of zero is taken as one cycle
  assign rep_load_w = (CFG_IN.repeat_cnt == pmg_pkg::REP_RST) ? pmg_pkg::REP_ONE : CFG_IN.repeat_cnt;

  assign run_d = start_w ? 1'b1 :
                 stop_w  ? 1'b0 : run_q;

  assign presc_d = (start_w || !run_q || tick_w) ? pmg_pkg::PRE_RST :
                   presc_q + 8'h01;

  assign cnt_d = (start_w || stop_w)  ? pmg_pkg::CNT_RST :
                 !(run_q && tick_w)   ? cnt_q :
                 at_term_w            ? pmg_pkg::CNT_RST :
                 cnt_q + 16'h0001;

  assign rem_d = start_w                        ? rep_load_w :
                 (wrap_w && !CFG_IN.continuous) ? rem_q - 8'h01 : rem_q;

  // Completion sets even in the cycle software clears it
  assign done_d = last_w || (done_q && !DONE_CLR_IN);

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      run_q   <= 1'b0;
      cnt_q   <= pmg_pkg::CNT_RST;
      presc_q <= pmg_pkg::PRE_RST;
      rem_q   <= pmg_pkg::REP_RST;
    end else begin
      run_q   <= run_d;
      cnt_q   <= cnt_d;
      presc_q <= presc_d;
      rem_q   <= rem_d;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      done_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      done_q <= done_d;
      irq_q  <= done_q && CFG_IN.irq_en;
    end
  end

  // ----------------------------------------------------------------------
  // Output lines
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < pmg_pkg::NUM_OUT; i++) begin : g_line
      pmg_channel u_line (
        .clk_in   (CLK_SYS_IN),
        .rst_n_in (RESETN_IN),
        .run_in   (run_q),
        .tick_in  (tick_w),
        .wrap_in  (wrap_w),
        .load_in  (start_w),
        .cnt_in   (cnt_q),
        .en_in    (CFG_IN.out_en[i]),
        .init_in  (CFG_IN.init_lvl[i]),
        .chan_in  (CHAN_IN[i]),
        .out_q    (PWM_OUT[i])
      );
    end
  endgenerate

  assign CNT_OUT  = cnt_q;
  assign BUSY_OUT = run_q;
  assign DONE_OUT = done_q;
  assign IRQ_OUT  = irq_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_last_wrap;
    run_q && tick_w && at_term_w && !CFG_IN.continuous && (rem_q == pmg_pkg::REP_ONE);
  endsequence

  sequence s_stopped_done;
    !run_q && done_q && (cnt_q == pmg_pkg::CNT_RST);
  endsequence

  sequence s_idle_start;
    !run_q && START_IN;
  endsequence

  counter_wrap_a: assert property (
    (run_q && tick_w && at_term_w && !STOP_IN) |=> (cnt_q == pmg_pkg::CNT_RST) && (run_q != $past(last_w)))
    else $error("counter did not wrap at the terminal value");

  counter_step_a: assert property (
    (run_q && tick_w && !at_term_w && !STOP_IN) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("counter did not advance by one on a tick");

  prescale_hold_a: assert property (
    (run_q && !tick_w && !STOP_IN) |=> $stable(cnt_q) && (presc_q == $past(presc_q) + 8'h01))
    else $error("counter moved between prescaler ticks");

  finite_stop_a: assert property (
    s_last_wrap |=> s_stopped_done)
    else $error("finite sequence did not stop and flag completion");

  endless_run_a: assert property (
    (wrap_w && CFG_IN.continuous && !STOP_IN) |=> run_q ##0 $stable(rem_q))
    else $error("continuous mode stopped or counted cycles");

  soft_start_a: assert property (
    s_idle_start |=> run_q && (cnt_q == pmg_pkg::CNT_RST) && (rem_q != pmg_pkg::REP_RST))
    else $error("software start did not begin a sequence");

  trig_start_a: assert property (
    (!run_q && CFG_IN.trig_en && $rose(trig_s2_q) && trig_s3_q == 1'b0 && !STOP_IN) |=> run_q)
    else $error("trigger edge did not begin a sequence");

  done_sticky_a: assert property (
    (done_q && !DONE_CLR_IN) |=> done_q)
    else $error("completion flag dropped without a clear");

  irq_follow_a: assert property (
    (done_q && CFG_IN.irq_en) ##1 (done_q && CFG_IN.irq_en) |-> IRQ_OUT)
    else $error("interrupt not raised for a pending flag");

endmodule : pmg_top

`default_nettype wire

// File: rtl/pmg_pkg.sv
/*
  Shared constants and carrier types of the multi-edge pulse generator.
  Assumes nothing of its surroundings; included by package reference only.
*/
`default_nettype none

package pmg_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_OUT  = 8;
  localparam int NUM_EDGE = 8;
  localparam int CNT_W    = 16;
  localparam int PRE_W    = 8;
  localparam int REP_W    = 8;

  // ----------------------------------------------------------------------
  // Reset values and the one-cycle repeat count
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0]   CNT_RST  = 16'h0000;
  localparam logic [PRE_W-1:0]   PRE_RST  = 8'h00;
  localparam logic [REP_W-1:0]   REP_RST  = 8'h00;
  localparam logic [REP_W-1:0]   REP_ONE  = 8'h01;
  localparam logic [NUM_OUT-1:0] PWM_RST  = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [CNT_W-1:0] pmg_cnt_t;

  typedef struct packed {
    logic [NUM_EDGE-1:0]            edge_en;
    logic [NUM_EDGE-1:0][CNT_W-1:0] edge_val;
  } pmg_chan_t;

  typedef pmg_chan_t [NUM_OUT-1:0] pmg_chan_tab_t;

  typedef struct packed {
    logic               presc_en;
    logic [PRE_W-1:0]   prescale;
    pmg_cnt_t           terminal;
    logic [NUM_OUT-1:0] init_lvl;
    logic [NUM_OUT-1:0] out_en;
    logic               continuous;
    logic [REP_W-1:0]   repeat_cnt;
    logic               trig_en;
    logic               irq_en;
  } pmg_cfg_t;

endpackage : pmg_pkg

`default_nettype wire

// File: rtl/pmg_channel.sv
/*
  One output line of the pulse generator: eight transition comparators
  and the output flip-flop.
  Assumes the shared counter, tick and wrap strobes come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pmg_channel (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Shared timing
  input  wire logic              run_in,
  input  wire logic              tick_in,
  input  wire logic              wrap_in,
  input  wire logic              load_in,
  input  wire pmg_pkg::pmg_cnt_t cnt_in,
  // Per-line setup
  input  wire logic              en_in,
  input  wire logic              init_in,
  input  wire pmg_pkg::pmg_chan_t chan_in,
  // Line
  output logic                   out_q
);

  logic [pmg_pkg::NUM_EDGE-1:0] match_w;
  logic                         hit_w;
  logic                         out_d;

  // ----------------------------------------------------------------------
  // Transition comparators
  // ----------------------------------------------------------------------
  genvar e;
  generate
    for (e = 0; e < pmg_pkg::NUM_EDGE; e++) begin : g_edge
      assign match_w[e] = chan_in.edge_en[e] && (chan_in.edge_val[e] == cnt_in);
    end
  endgenerate

  // Equal values on two edges give one toggle, not a cancelled pair
  assign hit_w = |match_w;

  // Reload beats a toggle that lands on the terminal value
  assign out_d = !en_in                         ? 1'b0    :
                 (load_in || wrap_in || !run_in) ? init_in :
                 (tick_in && hit_w)             ? !out_q  : out_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  line_toggle_a: assert property (
    (en_in && run_in && tick_in && hit_w && !wrap_in && !load_in) |=> (out_q != $past(out_q)))
    else $error("line did not toggle on a transition match");

  line_reload_a: assert property (
    (en_in && wrap_in) |=> (out_q == $past(init_in)))
    else $error("line did not reload its initial level on wrap");

  line_disable_a: assert property (
    !en_in |=> !out_q)
    else $error("disabled line is driven high");

endmodule : pmg_channel

`default_nettype wire

// File: dv/pmg_trig_src.sv
/*
  Model of the outside logic that fires the trigger pin.
  Assumes the bench asks for a trigger on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pmg_trig_src (
  // Request
  input  wire logic clk_in,
  input  wire logic fire_in,
  // Pin
  output var logic  trig_out
);
  initial trig_out = 1'b0;
  // Off-edge rise and fall, held long enough for the two-stage sampler
  always @(posedge clk_in) begin
    if (fire_in) begin
      #1 trig_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 trig_out = 1'b0;
    end
  end
endmodule : pmg_trig_src

`default_nettype wire

// File: dv/tb_pmg_top.sv
/*
  Self-checking bench of the pulse generator with a per-cycle reference.
  Assumes the package and the trigger model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end

module tb_pmg_top;
  logic                   clk, rst_n, start, stop, dclr, fire, trig, busy, done, irq;
  pmg_pkg::pmg_cfg_t      cfg;
  pmg_pkg::pmg_chan_tab_t chan;
  logic [7:0]             pwm;
  pmg_pkg::pmg_cnt_t      cnt;
  logic [31:0]            seed = 32'h00000025;
  logic [23:0]            expq[$];
  logic [23:0]            e;
  int                     num_errors = 0;
  int                     total_checks = 0;

  pmg_top uut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CFG_IN(cfg), .CHAN_IN(chan), .START_IN(start),
    .STOP_IN(stop), .TRIG_IN(trig), .DONE_CLR_IN(dclr), .PWM_OUT(pwm), .CNT_OUT(cnt),
    .BUSY_OUT(busy), .DONE_OUT(done), .IRQ_OUT(irq));
  pmg_trig_src trg (.clk_in(clk), .fire_in(fire), .trig_out(trig));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------
  // Reference: one entry of {lines, counter} per busy cycle
  // ----------------------------------------------------------------------
  task automatic plan(input int lim);
    pmg_pkg::pmg_cnt_t c;
    logic [7:0]        p, tog, pc;
    int                w;
    c = '0;
    p = cfg.init_lvl & cfg.out_en;
    pc = '0;
    w = 0;
    while (expq.size() < lim) begin
      expq.push_back({p, c});
      tog = '0;
      for (int i = 0; i < 8; i++) begin
        for (int k = 0; k < 8; k++) begin
          if (chan[i].edge_en[k] && chan[i].edge_val[k] == c) tog[i] = 1'b1;
        end
      end
      if (!cfg.presc_en || pc == cfg.prescale) begin
        pc = '0;
        if (c == cfg.terminal) begin
          w++;
          if (!cfg.continuous && w >= (cfg.repeat_cnt == 0 ? 1 : cfg.repeat_cnt)) break;
          c = '0;
          p = cfg.init_lvl & cfg.out_en;
        end else begin
          c++;
          p ^= tog & cfg.out_en;
        end
      end else pc++;
    end
  endtask : plan

  task automatic run(input logic pe, input logic [7:0] ps, input logic [15:0] t, input logic [7:0] rep,
                     input logic cont, input logic tm, input logic ie);
    int n;
    cfg = '{presc_en: pe, prescale: ps, terminal: t, init_lvl: 8'(rnd()), out_en: 8'(rnd()),
            continuous: cont, repeat_cnt: rep, trig_en: tm, irq_en: ie};
    for (int i = 0; i < 8; i++) begin
      chan[i].edge_en = 8'(rnd());
      for (int k = 0; k < 8; k++) chan[i].edge_val[k] = 16'(rnd() % (t + 1));
    end
    plan(cont ? 60 : 100000);
    if (tm) fire = 1'b1;
    else start = 1'b1;
    @(posedge clk) #1;
    fire = 1'b0;
    start = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK(busy, 1'b1)
    if (cont) begin
      repeat (20) @(posedge clk) #1;
      start = 1'b1;
      @(posedge clk) #1;
      start = 1'b0;
      stop = 1'b1;
      @(posedge clk) #1;
      stop = 1'b0;
      `CHK({busy, cnt, done}, 18'h00000)
      expq.delete();
    end else begin
      n = 0;
      while (busy === 1'b1 && n < 100000) begin
        @(posedge clk) #1;
        n++;
      end
      `CHK(expq.size() == 0, 1'b1)
      `CHK({busy, cnt, done}, 18'h00001)
      @(posedge clk) #1;
      `CHK(irq, ie)
      dclr = 1'b1;
      @(posedge clk) #1;
      dclr = 1'b0;
      `CHK(done, 1'b0)
    end
  endtask : run

  // ----------------------------------------------------------------------
  // Stimulus, monitor and watchdog
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    #2;
    if (busy === 1'b1) begin
      if (expq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = expq.pop_front();
        `CHK({pwm, cnt}, e)
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    {start, stop, dclr, fire} = 4'h0;
    cfg = '0;
    chan = '0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK({pwm, cnt, busy, done, irq}, 27'h0000000)
    run(1'b0, 8'h00, 16'h0017, 8'h02, 1'b0, 1'b0, 1'b1);
    run(1'b1, 8'h02, 16'h0009, 8'h00, 1'b0, 1'b0, 1'b0);
    run(1'b0, 8'h00, 16'h0001, 8'hFF, 1'b0, 1'b1, 1'b1);
    run(1'b1, 8'h00, 16'h0005, 8'h00, 1'b1, 1'b1, 1'b0);
    end_sim();
  end

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule : tb_pmg_top

`default_nettype wire
